// ==== core/psp_port.sv ====
`timescale 1ns/1ps
module psp_port
#(
   parameter int PORT_W = 8
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] data_port_in,
   output logic [7:0] data_port_out,
   output logic [7:0] data_port_oe,
   input wire logic [7:0] control_port_in,
   output logic [7:0] control_port_out,
   output logic [7:0] control_port_oe,
   output logic irq
);

   // ************************************************************
   // Registers
   // ************************************************************
   logic mode_r;
   logic in_full_r;
   logic out_full_r;
   logic ovf_r;
   logic [PORT_W-1:0] in_byte_r;
   logic [PORT_W-1:0] data_latch_r;
   logic [7:0] data_dir_r;
   logic [7:0] ctrl_latch_r;
   logic [7:0] ctrl_dir_r;
   logic [3:0] analog_r;
   logic [1:0] irq_stat_r;
   logic [1:0] irq_mask_r;
   logic int_mem_r;
   logic wr_active_r;
   logic rd_active_r;
   logic [7:0] aw_addr_r;
   logic aw_have_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic w_have_r;
   psp_pkg::psp_strobe_type strobe;

   // ************************************************************
   // Elaboration check
   // ************************************************************
   // Host bus and register byte lane are one byte; nothing else is served
   if (PORT_W != 8)
   begin : g_width_check
      $error("psp_port serves a port width of 8 only");
   end

   // ************************************************************
   // Slave port decode
   // ************************************************************
   wire strobes_in = &ctrl_dir_r[2:0];
   wire strobes_dig = &analog_r[2:0];
   wire psp_on = mode_r & int_mem_r & strobes_in & strobes_dig;
   // Strobe pins are all active low; each struct field takes its own control pin
   assign strobe = '{
      cs_n: control_port_in[psp_pkg::BIT_CS],
      wr_n: control_port_in[psp_pkg::BIT_WR],
      rd_n: control_port_in[psp_pkg::BIT_RD]
   };
   wire wr_low = psp_on & ~strobe.cs_n & ~strobe.wr_n;
   wire rd_low = psp_on & ~strobe.cs_n & ~strobe.rd_n;
   wire host_wr = wr_low & ~wr_active_r;
   wire host_rd = rd_low & ~rd_active_r;

   // ************************************************************
   // AXI write path
   // ************************************************************
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire do_wr = aw_have_r & w_have_r & ~s_axi_bvalid;
   wire lane0 = w_strb_r[0];
   wire [7:0] wb = w_data_r[7:0];
   wire wa_ctl = aw_addr_r == psp_pkg::ADDR_CONTROL;
   wire wa_dpin = aw_addr_r == psp_pkg::ADDR_DATA_PINS;
   wire wa_dlat = aw_addr_r == psp_pkg::ADDR_DATA_LATCH;
   wire wa_ddir = aw_addr_r == psp_pkg::ADDR_DATA_DIR;
   wire wa_cpin = aw_addr_r == psp_pkg::ADDR_CTRL_PINS;
   wire wa_clat = aw_addr_r == psp_pkg::ADDR_CTRL_LATCH;
   wire wa_cdir = aw_addr_r == psp_pkg::ADDR_CTRL_DIR;
   wire wa_anl = aw_addr_r == psp_pkg::ADDR_ANALOG_CFG;
   wire wa_ist = aw_addr_r == psp_pkg::ADDR_IRQ_STATUS;
   wire wa_imk = aw_addr_r == psp_pkg::ADDR_IRQ_MASK;
   wire wa_sys = aw_addr_r == psp_pkg::ADDR_SYS_MODE;
   wire wa_ok = wa_ctl | wa_dpin | wa_dlat | wa_ddir | wa_cpin | wa_clat
      | wa_cdir | wa_anl | wa_ist | wa_imk | wa_sys;
   wire we = do_wr & lane0;
   wire we_dlat = we & (wa_dpin | wa_dlat);
   wire we_clat = we & (wa_cpin | wa_clat);

   // ************************************************************
   // AXI read path
   // ************************************************************
   wire rd_take = s_axi_arvalid & s_axi_arready;
   wire [7:0] ra = s_axi_araddr;
   wire ra_ctl = ra == psp_pkg::ADDR_CONTROL;
   wire ra_dpin = ra == psp_pkg::ADDR_DATA_PINS;
   wire ra_dlat = ra == psp_pkg::ADDR_DATA_LATCH;
   wire ra_ddir = ra == psp_pkg::ADDR_DATA_DIR;
   wire ra_cpin = ra == psp_pkg::ADDR_CTRL_PINS;
   wire ra_clat = ra == psp_pkg::ADDR_CTRL_LATCH;
   wire ra_cdir = ra == psp_pkg::ADDR_CTRL_DIR;
   wire ra_anl = ra == psp_pkg::ADDR_ANALOG_CFG;
   wire ra_ist = ra == psp_pkg::ADDR_IRQ_STATUS;
   wire ra_imk = ra == psp_pkg::ADDR_IRQ_MASK;
   wire ra_sys = ra == psp_pkg::ADDR_SYS_MODE;
   wire [7:0] ctl_view = {in_full_r, out_full_r, ovf_r, mode_r, 4'h0};
   // In slave mode the pins view of the data port is the received byte
   wire [7:0] dpin_view = psp_on ? in_byte_r : data_port_in;
   wire [7:0] cpin_view = {5'h00, control_port_in[2:0]};
   logic [7:0] rd_byte;
   always_comb
   begin
      if (ra_ctl)
         rd_byte = ctl_view;
      else if (ra_dpin)
         rd_byte = dpin_view;
      else if (ra_dlat)
         rd_byte = data_latch_r;
      else if (ra_ddir)
         rd_byte = data_dir_r;
      else if (ra_cpin)
         rd_byte = cpin_view;
      else if (ra_clat)
         rd_byte = {5'h00, ctrl_latch_r[2:0]};
      else if (ra_cdir)
         rd_byte = ctrl_dir_r;
      else if (ra_anl)
         rd_byte = {4'h0, analog_r};
      else if (ra_ist)
         rd_byte = {6'h00, irq_stat_r};
      else if (ra_imk)
         rd_byte = {6'h00, irq_mask_r};
      else if (ra_sys)
         rd_byte = {7'h00, int_mem_r};
      else
         rd_byte = 8'h00;
   end
   wire ra_ok = ra_ctl | ra_dpin | ra_dlat | ra_ddir | ra_cpin | ra_clat
      | ra_cdir | ra_anl | ra_ist | ra_imk | ra_sys;
   wire cpu_rd_data = rd_take & ra_dpin & psp_on;

   // ************************************************************
   // Flag next values; hardware set wins over clear
   // ************************************************************
   wire in_full_nxt = host_wr | (in_full_r & ~cpu_rd_data);
   wire out_full_nxt = (we_dlat & psp_on) | (out_full_r & ~host_rd);
   wire ovf_clr = we & wa_ctl & ~wb[psp_pkg::BIT_OVERFLOW];
   wire ovf_nxt = (host_wr & in_full_r) | (ovf_r & ~ovf_clr);
   wire [1:0] ev = {host_wr, host_rd};
   wire [1:0] w1c = (we & wa_ist) ? wb[1:0] : 2'b00;
   wire [1:0] irq_stat_nxt = ev | (irq_stat_r & ~w1c);

   // ************************************************************
   // AXI handshakes
   // ************************************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= psp_pkg::RESP_OKAY;
      end
      else
      begin
         if (aw_take)
         begin
            aw_addr_r <= s_axi_awaddr;
            aw_have_r <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (w_take)
         begin
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
            w_have_r <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_wr)
         begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wa_ok ? psp_pkg::RESP_OKAY : psp_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid & s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= psp_pkg::RESP_OKAY;
      end
      else if (rd_take)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, rd_byte};
         s_axi_rresp <= ra_ok ? psp_pkg::RESP_OKAY : psp_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid & s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ************************************************************
   // Configuration registers
   // ************************************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mode_r <= psp_pkg::RST_MODE;
         data_dir_r <= psp_pkg::RST_DIR;
         ctrl_dir_r <= psp_pkg::RST_DIR;
         ctrl_latch_r <= psp_pkg::RST_BYTE;
         analog_r <= psp_pkg::RST_ANALOG;
         irq_mask_r <= psp_pkg::RST_IRQ;
         int_mem_r <= psp_pkg::RST_INT_MEM;
      end
      else
      begin
         if (we)
         begin
            if (wa_ctl)
               mode_r <= wb[psp_pkg::BIT_MODE];
            else if (wa_ddir)
               data_dir_r <= wb;
            else if (wa_cdir)
               ctrl_dir_r <= wb;
            else if (we_clat)
               ctrl_latch_r <= wb;
            else if (wa_anl)
               analog_r <= wb[3:0];
            else if (wa_imk)
               irq_mask_r <= wb[1:0];
            else if (wa_sys)
               int_mem_r <= wb[0];
         end
      end
   end

   // ************************************************************
   // Slave port state
   // ************************************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         in_full_r <= 1'b0;
         out_full_r <= 1'b0;
         ovf_r <= 1'b0;
         in_byte_r <= psp_pkg::RST_BYTE;
         data_latch_r <= psp_pkg::RST_BYTE;
         irq_stat_r <= psp_pkg::RST_IRQ;
      end
      else
      begin
         in_full_r <= in_full_nxt;
         out_full_r <= out_full_nxt;
         ovf_r <= ovf_nxt;
         irq_stat_r <= irq_stat_nxt;
         if (host_wr)
            in_byte_r <= data_port_in;
         if (we_dlat)
            data_latch_r <= wb;
      end
   end

   // ************************************************************
   // Strobe history
   // ************************************************************
   // A host may hold its strobes low for many clocks; only the first
   // cycle of a low pair counts, and a release rearms the detector
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wr_active_r <= 1'b0;
         rd_active_r <= 1'b0;
      end
      else
      begin
         wr_active_r <= wr_low;
         rd_active_r <= rd_low;
      end
   end

   // ************************************************************
   // Pins
   // ************************************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         data_port_out <= psp_pkg::RST_BYTE;
         data_port_oe <= 8'h00;
         control_port_out <= psp_pkg::RST_BYTE;
         control_port_oe <= 8'h00;
      end
      else
      begin
         data_port_out <= data_latch_r;
         // Host read drives the latch from one clock after select and read go low until one clock after they rise
         data_port_oe <= psp_on ? {8{rd_low}} : ~data_dir_r;
         control_port_out <= {5'h00, ctrl_latch_r[2:0]};
         control_port_oe <= {5'h00, ~ctrl_dir_r[2:0]};
      end
   end

   // ************************************************************
   // Interrupt
   // ************************************************************
   // Built from the next status so the request rises with its flag;
   // a mask change shows one clock after it is written
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq <= 1'b0;
      else
         irq <= |(irq_stat_nxt & irq_mask_r);
   end

endmodule : psp_port

// ==== core/psp_pkg.sv ====
package psp_pkg;

   // ************************************************************
   // Register map (byte addresses)
   // ************************************************************
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_DATA_PINS = 8'h04;
   localparam logic [7:0] ADDR_DATA_LATCH = 8'h08;
   localparam logic [7:0] ADDR_DATA_DIR = 8'h0C;
   localparam logic [7:0] ADDR_CTRL_PINS = 8'h10;
   localparam logic [7:0] ADDR_CTRL_LATCH = 8'h14;
   localparam logic [7:0] ADDR_CTRL_DIR = 8'h18;
   localparam logic [7:0] ADDR_ANALOG_CFG = 8'h1C;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;
   localparam logic [7:0] ADDR_SYS_MODE = 8'h28;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int BIT_IN_FULL = 7;
   localparam int BIT_OUT_FULL = 6;
   localparam int BIT_OVERFLOW = 5;
   localparam int BIT_MODE = 4;
   localparam int BIT_RD = 0;
   localparam int BIT_WR = 1;
   localparam int BIT_CS = 2;
   localparam int IRQ_RD = 0;
   localparam int IRQ_WR = 1;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [7:0] RST_DIR = 8'hFF;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_ANALOG = 4'h0;
   localparam logic [1:0] RST_IRQ = 2'h0;
   localparam logic RST_MODE = 1'h0;
   localparam logic RST_INT_MEM = 1'h1;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic cs_n;
      logic wr_n;
      logic rd_n;
   } psp_strobe_type;

endpackage : psp_pkg

// ==== test/psp_port_sva.sv ====
`timescale 1ns/1ps
// ****************************************
// Port checker
// ****************************************
module psp_port_sva
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] control_port_out,
   input wire logic [7:0] control_port_oe,
   input wire logic irq
);
   logic [7:0] ar_r;
   logic ctl_rd;
   // Address of the read in flight, to tell which register answers
   always_ff @(posedge aclk)
   begin
      if (s_axi_arvalid && s_axi_arready)
      begin
         ar_r <= s_axi_araddr;
      end
   end
   assign ctl_rd = s_axi_rvalid && ar_r == psp_pkg::ADDR_CONTROL;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_ctrl_low_zero: assert property (ctl_rd |-> s_axi_rdata[3:0] == 4'h0)
      else $error("control low bits not zero");
   a_ctrl_byte_wide: assert property (ctl_rd |-> s_axi_rdata[31:8] == 0)
      else $error("control read wider than a byte");
   a_pins_upper_idle: assert property (control_port_oe[7:3] == 5'h00
      && control_port_out[7:3] == 5'h00) else $error("upper control pins used");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid) else $error("write response dropped");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read answer late");
   a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("address taken during response");
   a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken during response");
   a_irq_quiet: assert property ($rose(aresetn) |-> !irq)
      else $error("interrupt out of reset");
endmodule : psp_port_sva

// ==== test/psp_host_model.sv ====
`timescale 1ns/1ps
// ****************************************
// Host processor on the slave port
// ****************************************
module psp_host_model
(
   input wire logic aclk,
   input wire logic [7:0] dut_out,
   input wire logic [7:0] dut_oe,
   output logic [7:0] bus,
   output psp_pkg::psp_strobe_type strb
);
   logic [7:0] drv_r = 8'h00;
   logic en_r = 1'b0;
   // Released bus shows inverted data so a stale byte never matches
   assign bus = (dut_oe & dut_out) | (~dut_oe & (en_r ? drv_r : ~drv_r));
   initial strb = 3'h7;
   task host_write(input logic [7:0] d);
      @(posedge aclk);
      drv_r <= d;
      en_r <= 1'b1;
      strb <= 3'h1;
      repeat (3) @(posedge aclk);
      strb <= 3'h7;
      @(posedge aclk);
      en_r <= 1'b0;
   endtask : host_write
   task host_read(output logic [7:0] d);
      @(posedge aclk);
      strb <= 3'h2;
      repeat (3) @(posedge aclk);
      d = bus;
      strb <= 3'h7;
      @(posedge aclk);
   endtask : host_read
endmodule : psp_host_model

// ==== test/psp_port_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
// ****************************************
// Bench
// ****************************************
module psp_port_tb_top;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [7:0] s_axi_awaddr, s_axi_araddr, data_port_in, data_port_out;
   logic [7:0] data_port_oe, control_port_in, control_port_out;
   logic [7:0] control_port_oe, hb;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   psp_pkg::psp_strobe_type strb;
   int fails = 0;
   int samples_checked = 0;
   localparam logic [7:0] GA [4] = '{psp_pkg::ADDR_CTRL_DIR,
      psp_pkg::ADDR_ANALOG_CFG, psp_pkg::ADDR_SYS_MODE, psp_pkg::ADDR_CONTROL};
   localparam logic [7:0] BAD [4] = '{8'hFB, 8'h03, 8'h00, 8'h00};
   localparam logic [7:0] GOOD [4] = '{8'hFF, 8'h07, 8'h01, 8'h10};
   localparam logic [1:0] OK = psp_pkg::RESP_OKAY;
   assign control_port_in = {5'h00, (control_port_oe[2:0]
      & control_port_out[2:0]) | (~control_port_oe[2:0] & strb)};
   psp_port i_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .data_port_in(data_port_in),
      .data_port_out(data_port_out), .data_port_oe(data_port_oe),
      .control_port_in(control_port_in),
      .control_port_out(control_port_out),
      .control_port_oe(control_port_oe), .irq(irq));
   psp_host_model i_host (.aclk(aclk), .dut_out(data_port_out),
      .dut_oe(data_port_oe), .bus(data_port_in), .strb(strb));
   initial
   begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   task wrap_up;
      $display("checks %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : wrap_up
   task lost(input int n);
      if (n >= 40)
      begin
         fails++;
         wrap_up();
      end
   endtask : lost
   task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end
      while (!s_axi_bvalid && n < 40);
      s_axi_bready <= 1'b0;
      lost(n);
      `CHK(s_axi_bresp, r)
   endtask : axi_wr
   task axi_rd(input logic [7:0] a, output logic [31:0] d,
      input logic [1:0] r);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end
      while (!s_axi_rvalid && n < 40);
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
      lost(n);
      `CHK(s_axi_rresp, r)
   endtask : axi_rd
   task ctl(input logic [31:0] e);
      axi_rd(psp_pkg::ADDR_CONTROL, rd, OK);
      `CHK(rd, e)
   endtask : ctl
   task t_reset;
      ctl(32'h00000000);
      axi_rd(psp_pkg::ADDR_CTRL_DIR, rd, OK);
      `CHK(rd, 32'h000000FF)
      axi_rd(8'h3C, rd, psp_pkg::RESP_SLVERR);
      axi_wr(8'h3C, 32'h000000FF, psp_pkg::RESP_SLVERR);
      axi_wr(psp_pkg::ADDR_CONTROL, 32'h0000001F, OK);
      ctl(32'h00000010);
      axi_wr(psp_pkg::ADDR_ANALOG_CFG, 32'h00000007, OK);
      axi_wr(psp_pkg::ADDR_IRQ_MASK, 32'h00000003, OK);
      // Lane 0 strobe low: the write is answered but changes nothing
      s_axi_wstrb <= 4'hE;
      axi_wr(psp_pkg::ADDR_IRQ_MASK, 32'h00000000, OK);
      s_axi_wstrb <= 4'hF;
      axi_rd(psp_pkg::ADDR_IRQ_MASK, rd, OK);
      `CHK(rd, 32'h00000003)
   endtask : t_reset
   task t_host_in;
      i_host.host_write(8'hA5);
      `CHK(irq, 1'b1)
      ctl(32'h00000090);
      i_host.host_write(8'h3C);
      ctl(32'h000000B0);
      axi_rd(psp_pkg::ADDR_DATA_PINS, rd, OK);
      `CHK(rd, 32'h0000003C)
      ctl(32'h00000030);
      axi_wr(psp_pkg::ADDR_CONTROL, 32'h00000010, OK);
      ctl(32'h00000010);
      axi_rd(psp_pkg::ADDR_IRQ_STATUS, rd, OK);
      `CHK(rd, 32'h00000002)
      axi_wr(psp_pkg::ADDR_IRQ_STATUS, 32'h00000002, OK);
      `CHK(irq, 1'b0)
   endtask : t_host_in
   task t_host_out;
      axi_wr(psp_pkg::ADDR_DATA_LATCH, 32'h0000005A, OK);
      ctl(32'h00000050);
      i_host.host_read(hb);
      `CHK(hb, 8'h5A)
      ctl(32'h00000010);
      `CHK(irq, 1'b1)
      axi_wr(psp_pkg::ADDR_IRQ_MASK, 32'h00000000, OK);
      // The new mask reaches the request one clock after the write
      @(posedge aclk);
      `CHK(irq, 1'b0)
      axi_wr(psp_pkg::ADDR_IRQ_STATUS, 32'h00000003, OK);
   endtask : t_host_out
   task t_gates;
      // Each entry disables the port one way, then restores it
      for (int i = 0; i < 4; i++)
      begin
         axi_wr(GA[i], {24'h000000, BAD[i]}, OK);
         i_host.host_write(8'h11);
         axi_rd(psp_pkg::ADDR_CONTROL, rd, OK);
         `CHK(rd[7], 1'b0)
         axi_wr(GA[i], {24'h000000, GOOD[i]}, OK);
      end
   endtask : t_gates
   initial
   begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_host_in();
      t_host_out();
      t_gates();
      wrap_up();
   end
endmodule : psp_port_tb_top
bind psp_port psp_port_sva i_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .control_port_out(control_port_out),
   .control_port_oe(control_port_oe), .irq(irq));
